// ---- dac_ctrl_pkg.sv ----
// Purpose: shared constants for the dac output update control core
// Assumes: 24-bit frames, one channel at address 0
// Notes:   command codes match the serial command byte
package dac_ctrl_pkg;

  // frame layout
  localparam int         FRAME_BITS   = 24;
  localparam int         CMD_MSB      = 23;
  localparam int         CMD_LSB      = 16;
  localparam logic [4:0] FRAME_COUNT  = 5'h18;
  localparam logic [4:0] CNT_RST      = 5'h00;

  // command bytes; low three bits of data commands carry the channel
  localparam logic [7:0] CMD_NOP      = 8'h00;
  localparam logic [7:0] CMD_CLEAR    = 8'h01;
  localparam logic [7:0] CMD_LOAD     = 8'h18;
  localparam logic [7:0] CMD_SWB      = 8'h28;
  localparam logic [7:0] CMD_PD       = 8'h30;
  localparam logic [7:0] CMD_WR       = 8'h08;
  localparam logic [7:0] CMD_STORE_AND_UPDATE_CMD     = 8'h10;
  localparam logic [7:0] CMD_STORE_ALL_UPDATE_CMD     = 8'h20;
  localparam logic [7:0] CMD_RD_PRE   = 8'h88;
  localparam logic [7:0] CMD_RD_OUT   = 8'h90;
  localparam logic [7:0] CMD_RD_CFG   = 8'h98;
  localparam logic [7:0] ADDR_MASK    = 8'hF8;

  // data field positions
  localparam int         CH0_BIT      = 0;
  localparam int         FLOAT_BIT    = 8;

  // configuration report layout
  localparam int         CFG_SWB_BIT  = 2;
  localparam int         CFG_PULL_BIT = 1;
  localparam int         CFG_HIZ_BIT  = 0;

  // reset and default values
  localparam logic [15:0] ZERO_CODE   = 16'h0000;
  localparam logic [15:0] MID_CODE    = 16'h8000;
  localparam logic        SWB_RST     = 1'b1;
  localparam logic        PD_RST      = 1'b0;
  localparam logic [23:0] SHIFT_RST   = 24'h000000;

  // cycles to wait after reset before the level select pin is trusted
  localparam logic [1:0]  INIT_CYCLES = 2'h3;
  localparam logic [1:0]  INIT_RST    = 2'h0;

endpackage : dac_ctrl_pkg

// ---- pin_sync.sv ----
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: inputs are asynchronous levels
// Notes:   first stage feeds only the second
`timescale 1ns/1ns
module pin_sync #(
  parameter int               W       = 1,
  parameter logic [W-1:0]     RST_VAL = '0
) (
  // clock and reset
  input  wire logic           ref_clk,
  input  wire logic           rst_n,
  // pins
  input  wire logic [W-1:0]   pin_in,
  output logic      [W-1:0]   pin_sync_out
);

  logic [W-1:0] meta_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q       <= RST_VAL;
      pin_sync_out <= RST_VAL;
    end else begin
      meta_q       <= pin_in;
      pin_sync_out <= meta_q;
    end
  end

endmodule : pin_sync

// ---- dac_output_update_control.sv ----
// Purpose: register transfer control of a single channel 16-bit dac
// Assumes: serial pins and level pins are asynchronous to ref_clk
// Notes:   frames decode when select_n rises after at least 24 sclk rises
`timescale 1ns/1ns
module dac_output_update_control (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // serial link
  input  wire logic        select_n,
  input  wire logic        sclk,
  input  wire logic        sdi,
  output logic             sdo,
  output logic             sdo_oe,
  // level pins
  input  wire logic        powerup_level_select_pin,
  input  wire logic        load_pin_n,
  input  wire logic        clear_pin_n,
  // converter side
  output logic [15:0]      dac_code_q,
  output logic             amp_enable_q,
  output logic             out_float_q,
  output logic             out_pulldown_q
);
  import dac_ctrl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers

  logic [5:0] pins_s;
  logic       sel_n_s;
  logic       sclk_s;
  logic       sdi_s;
  logic       level_s;
  logic       load_n_s;
  logic       clear_n_s;

  pin_sync #(
    .W       (6),
    .RST_VAL (6'h23)
  ) u_sync (
    .ref_clk      (ref_clk),
    .rst_n        (rst_n),
    .pin_in       ({select_n, sclk, sdi, powerup_level_select_pin, load_pin_n, clear_pin_n}),
    .pin_sync_out (pins_s)
  );

  assign {sel_n_s, sclk_s, sdi_s, level_s, load_n_s, clear_n_s} = pins_s;

  ////////////////////////////////////////////////////////////////////////////
  // edge detection

  logic sel_n_q;
  logic sclk_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_n_q <= 1'b1;
      sclk_q  <= 1'b0;
    end else begin
      sel_n_q <= sel_n_s;
      sclk_q  <= sclk_s;
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic sel_fall;
  logic sel_rise;

  assign sclk_rise = !sel_n_s && sclk_s && !sclk_q;
  assign sclk_fall = !sel_n_s && !sclk_s && sclk_q;
  assign sel_fall  = !sel_n_s && sel_n_q;
  assign sel_rise  = sel_n_s && !sel_n_q;

  ////////////////////////////////////////////////////////////////////////////
  // frame shift register and bit count

  logic [23:0] shift_q;
  logic [4:0]  bit_cnt_q;
  logic        frame_go;
  logic [7:0]  cmd;
  logic [15:0] data;

  assign frame_go = sel_rise && (bit_cnt_q == FRAME_COUNT);
  assign cmd      = shift_q[CMD_MSB:CMD_LSB];
  assign data     = shift_q[15:0];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_q <= CNT_RST;
    end else if (sel_fall) begin
      bit_cnt_q <= CNT_RST;
    end else if (sclk_rise && bit_cnt_q != FRAME_COUNT) begin
      bit_cnt_q <= bit_cnt_q + 5'h01;
    end
  end

  // command matchers
  function automatic logic is_ch0(input logic [7:0] c, input logic [7:0] base);
    is_ch0 = ((c & ADDR_MASK) == base) && (c[2:0] == 3'h0);
  endfunction : is_ch0

  logic do_wr;
  logic do_store_and_update_cmd;
  logic do_store_all_update_cmd;
  logic do_load;
  logic do_clear;
  logic do_swb;
  logic do_pd;
  logic do_rd_pre;
  logic do_rd_out;
  logic do_rd_cfg;

  assign do_wr     = frame_go && is_ch0(cmd, CMD_WR);
  assign do_store_and_update_cmd   = frame_go && is_ch0(cmd, CMD_STORE_AND_UPDATE_CMD);
  assign do_store_all_update_cmd   = frame_go && (cmd & ADDR_MASK) == CMD_STORE_ALL_UPDATE_CMD;
  assign do_load   = frame_go && cmd == CMD_LOAD && data[CH0_BIT];
  assign do_clear  = frame_go && cmd == CMD_CLEAR;
  assign do_swb    = frame_go && cmd == CMD_SWB;
  assign do_pd     = frame_go && cmd == CMD_PD;
  assign do_rd_pre = frame_go && is_ch0(cmd, CMD_RD_PRE);
  assign do_rd_out = frame_go && is_ch0(cmd, CMD_RD_OUT);
  assign do_rd_cfg = frame_go && is_ch0(cmd, CMD_RD_CFG);

  ////////////////////////////////////////////////////////////////////////////
  // configuration state

  logic       swb_q;
  logic       pd_float_q;
  logic       pd_pull_q;
  logic [7:0] cfg_report;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      swb_q      <= SWB_RST;
      pd_float_q <= PD_RST;
      pd_pull_q  <= PD_RST;
    end else if (do_clear) begin
      swb_q      <= SWB_RST;
      pd_float_q <= PD_RST;
      pd_pull_q  <= PD_RST;
    end else begin
      if (do_swb) begin
        swb_q <= data[CH0_BIT];
      end
      if (do_pd) begin
        pd_pull_q  <= data[CH0_BIT];
        pd_float_q <= data[FLOAT_BIT] && !data[CH0_BIT];
      end
    end
  end

  always_comb begin
    cfg_report               = 8'h00;
    cfg_report[CFG_SWB_BIT]  = swb_q;
    cfg_report[CFG_PULL_BIT] = pd_pull_q;
    cfg_report[CFG_HIZ_BIT]  = pd_float_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // power-up level capture

  logic [1:0]  init_cnt_q;
  logic        init_done;
  logic        init_load;
  logic [15:0] def_code;

  assign init_done = init_cnt_q == INIT_CYCLES;
  assign init_load = init_cnt_q == (INIT_CYCLES - 2'h1);
  assign def_code  = level_s ? MID_CODE : ZERO_CODE;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      init_cnt_q <= INIT_RST;
    end else if (!init_done) begin
      init_cnt_q <= init_cnt_q + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data registers

  logic [15:0] preload_q;
  logic        clear_any;

  assign clear_any = !clear_n_s || do_clear;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      preload_q <= ZERO_CODE;
    end else if (init_load || clear_any) begin
      preload_q <= def_code;
    end else if (do_wr || do_store_and_update_cmd || do_store_all_update_cmd) begin
      preload_q <= data;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dac_code_q <= ZERO_CODE;
    end else if (init_load || !clear_n_s) begin
      dac_code_q <= def_code;
    end else if (do_clear) begin
      dac_code_q <= def_code;
    end else if (do_store_and_update_cmd || do_store_all_update_cmd) begin
      dac_code_q <= data;
    end else if (do_wr && !swb_q) begin
      dac_code_q <= data;
    end else if (do_load) begin
      dac_code_q <= preload_q;
    end else if (!load_n_s && init_done) begin
      dac_code_q <= preload_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power-down outputs

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      amp_enable_q   <= 1'b1;
      out_float_q    <= 1'b0;
      out_pulldown_q <= 1'b0;
    end else begin
      amp_enable_q   <= !(pd_float_q || pd_pull_q);
      out_float_q    <= pd_float_q;
      out_pulldown_q <= pd_pull_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shift register and serial out

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_q <= SHIFT_RST;
    end else if (do_rd_pre) begin
      shift_q <= {cmd, preload_q};
    end else if (do_rd_out) begin
      shift_q <= {cmd, dac_code_q};
    end else if (do_rd_cfg) begin
      shift_q <= {cmd, 8'h00, cfg_report};
    end else if (sclk_rise) begin
      shift_q <= {shift_q[22:0], sdi_s};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sdo    <= 1'b0;
      sdo_oe <= 1'b0;
    end else begin
      sdo_oe <= !sel_n_s;
      if (sel_fall || sclk_fall) begin
        sdo <= shift_q[23];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_clear_forces_default: assert property (
    (!clear_n_s && init_done) |=> dac_code_q == $past(def_code))
    else $error("clear pin did not force default code");

  a_wr_block_holds: assert property (
    (do_wr && swb_q && clear_n_s && load_n_s)
      |=> (dac_code_q == $past(dac_code_q)) && (preload_q == $past(data)))
    else $error("write-block store changed output");

  a_wr_through_both: assert property (
    (do_wr && !swb_q && clear_n_s)
      |=> (dac_code_q == $past(data)) && (preload_q == $past(data)))
    else $error("write-through store missed a register");

  a_store_and_update_cmd_both_regs: assert property (
    ((do_store_and_update_cmd || do_store_all_update_cmd) && clear_n_s)
      |=> (dac_code_q == $past(data)) && (preload_q == $past(data)))
    else $error("update store missed a register");

  a_load_pin_copy: assert property (
    (!load_n_s && clear_n_s && init_done && !frame_go)
      |=> dac_code_q == $past(preload_q))
    else $error("load pin did not copy preload");

  a_soft_load_copy: assert property (
    (do_load && clear_n_s) |=> dac_code_q == $past(preload_q))
    else $error("soft load did not copy preload");

  a_pd_pull_wins: assert property (
    (do_pd && data[CH0_BIT]) |=> ##1 out_pulldown_q && !out_float_q && !amp_enable_q)
    else $error("pull-down did not win power-down select");

  a_short_frame_ignored: assert property (
    (sel_rise && bit_cnt_q != FRAME_COUNT && clear_n_s && load_n_s && init_done)
      |=> $stable(dac_code_q) && $stable(preload_q) && $stable(swb_q))
    else $error("short frame changed state");

  a_read_cfg_report: assert property (
    do_rd_cfg |=> shift_q[7:0] == $past(cfg_report) && shift_q[7:3] == 5'h00)
    else $error("config readback wrong");

  a_soft_clear_defaults: assert property (
    do_clear |=> swb_q == SWB_RST && !pd_pull_q && !pd_float_q
      && dac_code_q == $past(def_code))
    else $error("soft clear did not restore defaults");

  c_write_through: cover property (do_wr && !swb_q);
  c_block_then_load: cover property (do_wr && swb_q ##1 !load_n_s ##1 dac_code_q == preload_q);
  c_power_down_float: cover property (do_pd && data[FLOAT_BIT] && !data[CH0_BIT]);
  c_readback_pre: cover property (do_rd_pre);

endmodule : dac_output_update_control

// ---- spi_host_model.sv ----
// Purpose: serial host model driving select, clock and data
// Assumes: sclk idles low, msb first, 160 ns sclk period
// Notes:   sdi shows inverse of last bit between frames
`timescale 1ns/1ns
module spi_host_model (
  // serial link
  output logic      select_n,
  output logic      sclk,
  output logic      sdi,
  input  wire logic sdo
);
  initial begin
    select_n = 1'b1;
    sclk     = 1'b0;
    sdi      = 1'b0;
  end

  ////////////////////////////////////////////////////////////////
  // shift top n bits of w, capture sdo at each rise
  task automatic xfer(input int n, input logic [23:0] w, output logic [23:0] r);
    r = 24'h000000;
    select_n = 1'b0;
    #80;
    for (int i = 23; i > 23 - n; i--) begin
      sdi = w[i];
      #80;
      sclk = 1'b1;
      r    = {r[22:0], sdo};
      #80;
      sclk = 1'b0;
    end
    select_n = 1'b1;
    sdi      = ~sdi;
    #80;
  endtask : xfer
endmodule : spi_host_model

// ---- tb_dac_output_update_control.sv ----
// Purpose: self-checking bench for the dac update control core
// Assumes: host model drives the serial pins
// Notes:   level pins change at the falling clock edge
`timescale 1ns/1ns
module tb_dac_output_update_control;
  import dac_ctrl_pkg::*;
  logic        ref_clk, rst_n, lvl, load_n, clear_n;
  logic        select_n, sclk, sdi, sdo, sdo_oe, amp, flt, pdn;
  logic [15:0] code;
  logic [23:0] rx;
  wire         sdo_line;
  int          mismatches = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  logic [15:0] pd_d [3] = '{16'h0100, 16'h0001, 16'h0101};
  logic [1:0]  pd_e [3] = '{2'b10, 2'b01, 2'b01};

  assign sdo_line = sdo_oe ? sdo : 1'bz;

  dac_output_update_control dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .select_n(select_n), .sclk(sclk),
    .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .powerup_level_select_pin(lvl),
    .load_pin_n(load_n), .clear_pin_n(clear_n), .dac_code_q(code),
    .amp_enable_q(amp), .out_float_q(flt), .out_pulldown_q(pdn)
  );
  spi_host_model host (.select_n(select_n), .sclk(sclk), .sdi(sdi), .sdo(sdo_line));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      mismatches++;
      summarize();
    end
  end

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic send(input logic [7:0] c, input logic [15:0] d);
    host.xfer(24, {c, d}, rx);
  endtask : send

  task automatic read(input logic [7:0] c, output logic [15:0] d);
    send(c, 16'h0000);
    send(CMD_NOP, 16'h0000);
    check(rx[23:16], c);
    d = rx[15:0];
  endtask : read

  task automatic regs(input logic [15:0] p, input logic [15:0] o);
    logic [15:0] d;
    read(CMD_RD_PRE, d);
    check(d, p);
    read(CMD_RD_OUT, d);
    check(d, o);
    check(code, o);
  endtask : regs

  task automatic cfg(input logic [2:0] e);
    logic [15:0] d;
    read(CMD_RD_CFG, d);
    check(d[2:0], e);
  endtask : cfg

  ////////////////////////////////////////////////////////////////
  initial begin
    rst_n   = 1'b0;
    lvl     = 1'b1;
    load_n  = 1'b1;
    clear_n = 1'b1;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk) rst_n = 1'b1;
    repeat (10) @(negedge ref_clk);
    check(code, MID_CODE);
    check({amp, flt, pdn}, 3'b100);
    cfg(3'b100);
    // write-block store and loads
    send(CMD_WR, 16'h1234);
    regs(16'h1234, MID_CODE);
    send(CMD_LOAD, 16'h0001);
    check(code, 16'h1234);
    send(CMD_WR, 16'h5678);
    check(code, 16'h1234);
    @(negedge ref_clk) load_n = 1'b0;
    repeat (10) @(negedge ref_clk);
    check(code, 16'h5678);
    send(CMD_WR, 16'h9ABC);
    check(code, 16'h9ABC);
    @(negedge ref_clk) load_n = 1'b1;
    send(CMD_STORE_AND_UPDATE_CMD, 16'hFFFF);
    regs(16'hFFFF, 16'hFFFF);
    send(CMD_STORE_ALL_UPDATE_CMD, 16'h2222);
    regs(16'h2222, 16'h2222);
    // write-through
    send(CMD_SWB, 16'h0000);
    cfg(3'b000);
    send(CMD_WR, 16'h3333);
    check(code, 16'h3333);
    // refused frames: wrong channel, short frame
    send(CMD_WR | 8'h01, 16'h4444);
    host.xfer(23, {CMD_WR, 16'h5555}, rx);
    regs(16'h3333, 16'h3333);
    // power-down modes
    for (int k = 0; k < 3; k++) begin
      send(CMD_PD, pd_d[k]);
      check({amp, flt, pdn}, {1'b0, pd_e[k]});
      cfg({1'b0, pd_e[k][0], pd_e[k][1]});
    end
    send(CMD_STORE_AND_UPDATE_CMD, 16'h4321);
    regs(16'h4321, 16'h4321);
    send(CMD_PD, 16'h0000);
    check({amp, flt, pdn}, 3'b100);
    // clear pin
    @(negedge ref_clk) clear_n = 1'b0;
    repeat (10) @(negedge ref_clk);
    check(code, MID_CODE);
    @(negedge ref_clk) clear_n = 1'b1;
    regs(MID_CODE, MID_CODE);
    // mid-run reset with level pin low, then soft clear
    @(negedge ref_clk) rst_n = 1'b0;
    lvl = 1'b0;
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (10) @(negedge ref_clk);
    check(code, ZERO_CODE);
    send(CMD_STORE_AND_UPDATE_CMD, 16'h7777);
    send(CMD_SWB, 16'h0000);
    send(CMD_CLEAR, 16'h0000);
    regs(ZERO_CODE, ZERO_CODE);
    cfg(3'b100);
    summarize();
  end
endmodule : tb_dac_output_update_control
